//--- core/rsc_pkg.sv
/*
 * Shared constants, state codes and carrier structs for the reset source controller.
 * Assumes a single 200 MHz clock and that all users import this package.
 */
// Behaviour
// - Power-on resets everything, drives both pins, samples config
// - Boot source and word load only during power-on
// - Hard pin low forces soft pin low too
// - Both reset pins are open-drain, pull low only
// - Later hard resets keep the loaded boot word
// - Hard flow drives both pins and resets cores
// - External soft reset ignored while own reset runs
// - Soft flow: soft pin, core reset, config kept
// - Test port host command starts a soft flow
// - Enabled watchdog expiry starts a hard flow
// - Serial link reset request starts a hard flow
// - Software hard request starts a hard flow
// - Software soft request starts a soft flow
// - Status records sources of the latest reset
// - Config pins sampled only during power-on
// - Boot source chosen only during power-on
// - System configuration write only in power-on flow
// - Boundary test instructions act as soft source
// - Hard flow pin or internal; power-on pin only
package rsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int CFG_W = 8;   // Configuration strap pins
  localparam int BSRC_W = 3;  // Boot source strap pins
  localparam int WORD_W = 32; // Boot configuration word
  localparam int TAP_IR_W = 4; // Test port instruction register
  localparam int CNT_W = 10;  // Flow timer
  localparam int SYNC_W = 3 + CFG_W + BSRC_W;

  ////////////////////////////////////////////////////////////////////////////
  // Test port instruction codes that force a soft reset
  localparam logic [TAP_IR_W-1:0] TAP_EXTEST = 4'h0;
  localparam logic [TAP_IR_W-1:0] TAP_CLAMP = 4'h6;
  localparam logic [TAP_IR_W-1:0] TAP_HIGHZ = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Timing in ns, then in cycles of the 5 ns clock
  localparam int CLK_PERIOD_PS = 5000;
  localparam int POR_TAIL_NS = 250;  // Pins held after power-on input releases
  localparam int HARD_HOLD_NS = 500; // Pins held for a hard flow
  localparam int SOFT_HOLD_NS = 250; // Pin held for a soft flow
  // Least times, so round up
  localparam logic [CNT_W-1:0] POR_TAIL_CYC =
    CNT_W'((POR_TAIL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] HARD_HOLD_CYC =
    CNT_W'((HARD_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] SOFT_HOLD_CYC =
    CNT_W'((SOFT_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // Covers the two-flop pin synchroniser after releasing the pins
  localparam logic [CNT_W-1:0] SETTLE_CYC = 10'h004;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [SYNC_W-1:0] SYNC_RESET = '1; // Pins idle high
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
  localparam logic [BSRC_W-1:0] BSRC_RESET = 3'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Flow states, one-hot
  typedef enum logic [4:0] {
    RSC_IDLE = 5'b00001,
    RSC_POR = 5'b00010,
    RSC_HARD = 5'b00100,
    RSC_SOFT = 5'b01000,
    RSC_WAIT = 5'b10000
  } rsc_state_t;

  // Reset sources, one bit each
  typedef struct packed {
    logic power_on;
    logic hard_pin;
    logic soft_pin;
    logic watchdog;
    logic tap;
    logic serial_link;
    logic sw_hard;
    logic sw_soft;
  } rsc_status_t;

  // Values caught during power-on
  typedef struct packed {
    logic [CFG_W-1:0] config_pins;
    logic [BSRC_W-1:0] boot_source;
  } rsc_cfg_t;

endpackage

//--- core/rsc_reset_source_controller.sv
/*
 * Reset source controller: gathers power-on, pin, watchdog, test port,
 * serial link and software reset requests and runs a power-on, hard or soft flow.
 * Assumes internal requests come from logic on clk_in; pins are asynchronous
 * and the open-drain wires are resolved outside from the enables.
 */
`timescale 1ns/1ps
module rsc_reset_source_controller (
  // Clock and reset
  input wire logic clk_in,                      // 200 MHz
  input wire logic reset_n_in,                  // Async, active low
  // Reset pins
  input wire logic power_on_reset_n_in,         // Power-on pin, active low
  // Hard wire, open drain
  input wire logic hard_reset_pin_n_in,         // Hard reset wire level
  output logic hard_reset_pin_n_out,            // Always low when enabled
  output logic hard_reset_pin_oe_out,           // High while pulling low
  // Soft wire, open drain
  input wire logic soft_reset_pin_n_in,         // Soft reset wire level
  output logic soft_reset_pin_n_out,            // Always low when enabled
  output logic soft_reset_pin_oe_out,           // High while pulling low
  // Straps and boot word
  input wire logic [rsc_pkg::CFG_W-1:0] config_pins_in,
  input wire logic [rsc_pkg::BSRC_W-1:0] boot_source_pins_in,
  input wire logic [rsc_pkg::WORD_W-1:0] boot_config_word_in,
  input wire logic boot_config_word_valid_in,   // Word from boot source
  // Internal requests
  input wire logic watchdog_zero_in,            // Watchdog count at zero
  input wire logic watchdog_reset_en_in,        // Watchdog reset enabled
  input wire logic tap_host_reset_in,           // Test port host reset command
  input wire logic [rsc_pkg::TAP_IR_W-1:0] tap_instr_in,
  input wire logic serial_link_hard_reset_in,   // Serial link reset request
  input wire logic sw_hard_reset_in,            // Control register hard request
  input wire logic sw_soft_reset_in,            // Control register soft request
  // Resets and results
  output logic core_reset_out,                  // Cores held in reset
  output logic pll_reset_out,                   // PLL state reset
  output rsc_pkg::rsc_cfg_t sampled_cfg_out,    // Straps caught at power-on
  output logic [rsc_pkg::WORD_W-1:0] boot_config_word_out,
  output logic boot_config_valid_out,           // Boot word loaded
  output rsc_pkg::rsc_status_t reset_status_out, // Latest reset sources
  output logic status_ready_out                 // No flow running
);
  import rsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  // Synchronised pins
  logic [SYNC_W-1:0] pins_s;          // Synchronised pin group
  logic por_n_s;                      // Power-on pin, synchronised
  logic hard_n_s;                     // Hard wire, synchronised
  logic soft_n_s;                     // Soft wire, synchronised
  logic [CFG_W-1:0] cfg_s;            // Straps, synchronised
  logic [BSRC_W-1:0] bsrc_s;          // Boot source straps, synchronised

  // Flow control
  rsc_state_t state;                  // Current flow
  rsc_state_t next_state;             // Flow for next cycle
  logic [CNT_W-1:0] cnt;              // Hold and settle timer

  // Pin enables
  logic drive_hard;                   // Hard pin enable register
  logic drive_soft;                   // Soft pin enable register

  // Decoded requests
  logic por_req;                      // Power-on input asserted
  logic ext_hard;                     // Hard pin pulled by someone else
  logic ext_soft;                     // Soft pin pulled by someone else
  logic tap_soft;                     // Test port soft request
  logic hard_any;                     // Any hard-class request
  logic soft_any;                     // Any soft-class request
  rsc_status_t src_now;               // Requests seen this cycle

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; wires idle high
  rsc_sync2 #(
    .W(SYNC_W),
    .RESET_VAL(SYNC_RESET)
  ) u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in({power_on_reset_n_in, hard_reset_pin_n_in, soft_reset_pin_n_in,
               config_pins_in, boot_source_pins_in}),
    .sync_out(pins_s)
  );

  assign {por_n_s, hard_n_s, soft_n_s, cfg_s, bsrc_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode
  always_comb begin
    // Power-on only ever comes from the pin
    por_req = !por_n_s;
    // Our own hard drive masks the wire; settle window too
    ext_hard = !hard_n_s && !drive_hard && (state != RSC_WAIT);
    // Soft wire only counts when we assert nothing at all
    ext_soft = !soft_n_s && (state == RSC_IDLE);
    // Boundary instructions behave as a soft source
    tap_soft = tap_host_reset_in || (tap_instr_in == TAP_EXTEST) ||
               (tap_instr_in == TAP_CLAMP) || (tap_instr_in == TAP_HIGHZ);

    // Status bits for this cycle
    src_now.power_on = por_req;
    src_now.hard_pin = ext_hard;
    src_now.soft_pin = ext_soft;
    src_now.watchdog = watchdog_zero_in && watchdog_reset_en_in;
    src_now.tap = tap_soft;
    src_now.serial_link = serial_link_hard_reset_in;
    src_now.sw_hard = sw_hard_reset_in;
    src_now.sw_soft = sw_soft_reset_in;

    // Flow classes
    hard_any = src_now.hard_pin || src_now.watchdog || src_now.serial_link ||
               src_now.sw_hard;
    // Soft class
    soft_any = src_now.soft_pin || src_now.tap || src_now.sw_soft;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flow selection; power-on beats hard beats soft
  always_comb begin
    // Hold by default
    next_state = state;
    unique case (state)
      RSC_IDLE: begin
        // Widest request wins
        if (por_req) begin
          next_state = RSC_POR;
        end else if (hard_any) begin
          next_state = RSC_HARD;
        end else if (soft_any) begin
          next_state = RSC_SOFT;
        end
      end

      RSC_POR: begin
        // Tail timer only runs once the input lets go
        if (!por_req && cnt == '0) begin
          next_state = RSC_WAIT;
        end
      end

      RSC_HARD: begin
        // Only power-on preempts
        if (por_req) begin
          next_state = RSC_POR;
        end else if (cnt == '0) begin
          next_state = RSC_WAIT;
        end
      end

      RSC_SOFT: begin
        // Escalate to the wider flow if one is asked for
        if (por_req) begin
          next_state = RSC_POR;
        end else if (hard_any) begin
          next_state = RSC_HARD;
        end else if (cnt == '0) begin
          next_state = RSC_WAIT;
        end
      end

      RSC_WAIT: begin
        // Wait until the wires read released after our drive stops
        if (por_req) begin
          next_state = RSC_POR;
        end else if (cnt == '0 && !hard_n_s) begin
          next_state = RSC_HARD; // Someone else still holds hard
        end else if (cnt == '0 && soft_n_s) begin
          next_state = RSC_IDLE;
        end
      end

      default: begin
        next_state = RSC_IDLE; // Illegal code recovers
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // Idle after reset
      state <= RSC_IDLE;
    end else begin
      // Advance the flow
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flow timer, loaded on each state entry
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // Timer idle
      cnt <= '0;
    end else if (next_state != state || (state == RSC_POR && por_req)) begin
      unique case (next_state)
        // Load the new state's time
        RSC_POR: cnt <= POR_TAIL_CYC;
        RSC_HARD: cnt <= HARD_HOLD_CYC;
        RSC_SOFT: cnt <= SOFT_HOLD_CYC;
        RSC_WAIT: cnt <= SETTLE_CYC;
        // Idle needs no timer
        default: cnt <= '0;
      endcase
    end else if (cnt != '0) begin
      // Count down to zero
      cnt <= cnt - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; open-drain, so only the enable moves
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // Wires released
      drive_hard <= 1'b0;
      drive_soft <= 1'b0;
    end else begin
      // Pull hard in power-on and hard flows
      drive_hard <= (next_state == RSC_POR) || (next_state == RSC_HARD);
      // Soft follows hard, whoever pulls hard
      drive_soft <= (next_state == RSC_POR) || (next_state == RSC_HARD) ||
                    (next_state == RSC_SOFT) || !hard_n_s;
    end
  end

  assign hard_reset_pin_n_out = 1'b0;
  assign soft_reset_pin_n_out = 1'b0;

  // Enables straight from flops
  assign hard_reset_pin_oe_out = drive_hard;
  assign soft_reset_pin_oe_out = drive_soft;

  ////////////////////////////////////////////////////////////////////////////
  // Core and PLL resets; cores stay held until the wires settle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // Cores and PLLs held
      core_reset_out <= 1'b1;
      pll_reset_out <= 1'b1;
    end else begin
      // Cores free only in idle
      core_reset_out <= (next_state != RSC_IDLE);
      // Only power-on touches PLLs
      pll_reset_out <= (next_state == RSC_POR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Straps and boot source, caught only in the power-on flow
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // Straps unknown yet
      sampled_cfg_out.config_pins <= CFG_RESET;
      sampled_cfg_out.boot_source <= BSRC_RESET;
    end else if (state == RSC_POR && por_req) begin
      // Last value before release wins; hard and soft never touch these
      sampled_cfg_out.config_pins <= cfg_s;
      sampled_cfg_out.boot_source <= bsrc_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot word; loads only while the power-on input is asserted
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // No word loaded
      boot_config_word_out <= WORD_RESET;
      boot_config_valid_out <= 1'b0;
    end else if (next_state == RSC_POR && state != RSC_POR) begin
      boot_config_valid_out <= 1'b0; // New power-on forgets the old word
    end else if (state == RSC_POR && por_req && boot_config_word_valid_in) begin
      // Take the strobed word
      boot_config_word_out <= boot_config_word_in;
      boot_config_valid_out <= 1'b1;
    end
    // Hard and soft flows leave the word as loaded
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset status: new flow or power-on replaces, soft-to-hard escalation adds
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // No source seen
      reset_status_out <= '0;
    end else if (next_state != RSC_IDLE && (state == RSC_IDLE ||
                 (next_state == RSC_POR && state != RSC_POR))) begin
      // Fresh flow replaces
      reset_status_out <= src_now;
    end else if (state == RSC_POR || state == RSC_HARD || state == RSC_SOFT) begin
      // Sources joining a running flow belong to the same reset
      reset_status_out <= reset_status_out | src_now;
    end
  end

  // Status is meaningful once no flow is running
  assign status_ready_out = (state == RSC_IDLE);

endmodule

//--- core/rsc_sync2.sv
/*
 * Two-flop synchroniser, one stage pair per bit.
 * Assumes inputs come from pins or another clock; reset value is a constant.
 */
`timescale 1ns/1ps
module rsc_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Per-bit stages; the first flop feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta; // First stage, may go metastable
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          meta <= RESET_VAL[i];
          sync_out[i] <= RESET_VAL[i];
        end else begin
          meta <= async_in[i];
          sync_out[i] <= meta;
        end
      end
    end
  endgenerate

endmodule

//--- dv/rsc_board_model.sv
/*
 * Board side of the reset wires: pull-ups plus an outside host that may pull low.
 * Assumes the device enables and levels come straight from its ports.
 */
`timescale 1ns/1ps
module rsc_board_model (
  input wire logic hard_oe_in,
  input wire logic hard_n_in,
  input wire logic soft_oe_in,
  input wire logic soft_n_in,
  input wire logic ext_hard_pull_in,
  input wire logic ext_soft_pull_in,
  output logic hard_wire_n_out,
  output logic soft_wire_n_out
);
  // Pull-ups win unless someone pulls low; a driven high is not honoured
  assign hard_wire_n_out = !(ext_hard_pull_in || (hard_oe_in && !hard_n_in));
  assign soft_wire_n_out = !(ext_soft_pull_in || (soft_oe_in && !soft_n_in));
endmodule

//--- dv/rsc_chk.sv
/*
 * Checker for the reset source controller, watching its ports only.
 * Assumes one clock domain and open-drain wires resolved on the board.
 */
`timescale 1ns/1ps
module rsc_chk (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic hard_reset_pin_n_out,
  input wire logic hard_reset_pin_oe_out,
  input wire logic soft_reset_pin_n_out,
  input wire logic soft_reset_pin_oe_out,
  input wire logic watchdog_zero_in,
  input wire logic watchdog_reset_en_in,
  input wire logic tap_host_reset_in,
  input wire logic [rsc_pkg::TAP_IR_W-1:0] tap_instr_in,
  input wire logic serial_link_hard_reset_in,
  input wire logic sw_hard_reset_in,
  input wire logic sw_soft_reset_in,
  input wire logic core_reset_out,
  input wire logic pll_reset_out,
  input wire rsc_pkg::rsc_cfg_t sampled_cfg_out,
  input wire logic [rsc_pkg::WORD_W-1:0] boot_config_word_out,
  input wire rsc_pkg::rsc_status_t reset_status_out,
  input wire logic status_ready_out
);
  import rsc_pkg::*;
  logic [CNT_W-1:0] hard_cnt; // Cycles the hard pin enable has been high
  logic [CNT_W-1:0] soft_cnt; // Cycles the soft pin enable has been high
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  //////////////////////////////////////////////////////////////////////////////
  // Hold counters, cleared whenever the pull stops
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hard_cnt <= '0;
      soft_cnt <= '0;
    end else begin
      hard_cnt <= hard_reset_pin_oe_out ? hard_cnt + 1'b1 : '0;
      soft_cnt <= soft_reset_pin_oe_out ? soft_cnt + 1'b1 : '0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Properties
  property p_drain;
    !(hard_reset_pin_oe_out && hard_reset_pin_n_out) && !(soft_reset_pin_oe_out && soft_reset_pin_n_out);
  endproperty
  a_drain: assert property (p_drain) else $error("pin driven high");
  property p_echo;
    hard_reset_pin_oe_out |-> soft_reset_pin_oe_out;
  endproperty
  a_echo: assert property (p_echo) else $error("soft pin not pulled with hard");
  property p_sw_hard;
    status_ready_out && sw_hard_reset_in |=> hard_reset_pin_oe_out && core_reset_out && reset_status_out.sw_hard;
  endproperty
  a_sw_hard: assert property (p_sw_hard) else $error("software hard flow missing");
  property p_sw_soft;
    status_ready_out && sw_soft_reset_in && !sw_hard_reset_in && !serial_link_hard_reset_in &&
      !(watchdog_zero_in && watchdog_reset_en_in) |=>
      soft_reset_pin_oe_out && !hard_reset_pin_oe_out && core_reset_out;
  endproperty
  a_sw_soft: assert property (p_sw_soft) else $error("software soft flow wrong");
  property p_wd;
    status_ready_out && watchdog_zero_in && watchdog_reset_en_in |=> hard_reset_pin_oe_out && reset_status_out.watchdog;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog flow missing");
  property p_link;
    status_ready_out && serial_link_hard_reset_in |=> hard_reset_pin_oe_out && reset_status_out.serial_link;
  endproperty
  a_link: assert property (p_link) else $error("serial link flow missing");
  property p_tap;
    status_ready_out && (tap_host_reset_in || tap_instr_in == TAP_EXTEST || tap_instr_in == TAP_CLAMP ||
      tap_instr_in == TAP_HIGHZ) |=> soft_reset_pin_oe_out && core_reset_out;
  endproperty
  a_tap: assert property (p_tap) else $error("test port soft flow missing");
  property p_pll;
    $rose(pll_reset_out) |-> hard_reset_pin_oe_out && soft_reset_pin_oe_out && core_reset_out;
  endproperty
  a_pll: assert property (p_pll) else $error("power-on actions incomplete");
  property p_word;
    !pll_reset_out |=> $stable(boot_config_word_out);
  endproperty
  a_word: assert property (p_word) else $error("boot word changed outside power-on");
  property p_cfg;
    (hard_reset_pin_oe_out || soft_reset_pin_oe_out) && !pll_reset_out |=> $stable(sampled_cfg_out);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config resampled");
  property p_hard_hold;
    $fell(hard_reset_pin_oe_out) && !$past(pll_reset_out) |-> hard_cnt >= HARD_HOLD_CYC;
  endproperty
  a_hard_hold: assert property (p_hard_hold) else $error("hard flow too short");
  property p_soft_hold;
    $fell(soft_reset_pin_oe_out) && !$past(hard_reset_pin_oe_out) |-> soft_cnt >= SOFT_HOLD_CYC;
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("soft flow too short");
  // Main scenarios reached
  c_hard: cover property (status_ready_out && sw_hard_reset_in);
  c_por: cover property ($rose(pll_reset_out));
  c_soft: cover property ($fell(soft_reset_pin_oe_out) && !$past(hard_reset_pin_oe_out));
endmodule
bind rsc_reset_source_controller rsc_chk u_chk (.*);

//--- dv/testbench.sv
/*
 * Self-checking bench for the reset source controller.
 * Assumes the board model resolves the wires; inputs change on falling edges.
 */
`timescale 1ns/1ps
module testbench;
  import rsc_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic por_n = 1'b1, ext_hard = 1'b0, ext_soft = 1'b0, word_vld = 1'b0, wd_zero = 1'b0, wd_en = 1'b1;
  logic tap_host = 1'b0, link_req = 1'b0, sw_hard = 1'b0, sw_soft = 1'b0;
  logic [CFG_W-1:0] cfg_pins = 8'h3c;
  logic [BSRC_W-1:0] bsrc = 3'h5;
  logic [WORD_W-1:0] word = 32'h0000_0000;
  logic [TAP_IR_W-1:0] tap_ir = 4'hf; // Code that asks for nothing
  logic hard_n_w, soft_n_w, hard_n_o, hard_oe, soft_n_o, soft_oe, core_rst, pll_rst, vld, ready;
  logic [10:0] cfg_o;
  logic [7:0] stat; // {power_on,hard_pin,soft_pin,watchdog,tap,serial_link,sw_hard,sw_soft}
  logic [WORD_W-1:0] word_o;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  rsc_reset_source_controller uut (.clk_in(clk_in), .reset_n_in(reset_n_in), .power_on_reset_n_in(por_n),
    .hard_reset_pin_n_in(hard_n_w), .hard_reset_pin_n_out(hard_n_o), .hard_reset_pin_oe_out(hard_oe),
    .soft_reset_pin_n_in(soft_n_w), .soft_reset_pin_n_out(soft_n_o), .soft_reset_pin_oe_out(soft_oe),
    .config_pins_in(cfg_pins), .boot_source_pins_in(bsrc), .boot_config_word_in(word),
    .boot_config_word_valid_in(word_vld), .watchdog_zero_in(wd_zero), .watchdog_reset_en_in(wd_en),
    .tap_host_reset_in(tap_host), .tap_instr_in(tap_ir), .serial_link_hard_reset_in(link_req),
    .sw_hard_reset_in(sw_hard), .sw_soft_reset_in(sw_soft), .core_reset_out(core_rst), .pll_reset_out(pll_rst),
    .sampled_cfg_out(cfg_o), .boot_config_word_out(word_o), .boot_config_valid_out(vld),
    .reset_status_out(stat), .status_ready_out(ready));
  rsc_board_model u_board (.hard_oe_in(hard_oe), .hard_n_in(hard_n_o), .soft_oe_in(soft_oe), .soft_n_in(soft_n_o),
    .ext_hard_pull_in(ext_hard), .ext_soft_pull_in(ext_soft), .hard_wire_n_out(hard_n_w),
    .soft_wire_n_out(soft_n_w));
  //////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard, ceiling well above the roughly 1250 cycles used
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic final_report();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Bounded wait for the flow to finish, then state must stay what power-on left
  task automatic after_flow(input int b);
    int i;
    i = 0;
    while (ready !== 1'b1 && i < 400) begin
      cyc(1);
      i++;
    end
    chk("core reset", core_rst, 1'b0);
    chk("status bit", stat[b], 1'b1);
    chk("cfg kept", cfg_o, {8'h3c, 3'h5});
    chk("word kept", word_o, 32'h5a5a_0f0f);
    cyc(2);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_por();
    por_n = 1'b0;
    cyc(6);
    chk("pll", pll_rst, 1'b1);
    chk("hard wire", hard_n_w, 1'b0);
    chk("soft wire", soft_n_w, 1'b0);
    word = 32'h5a5a_0f0f;
    word_vld = 1'b1;
    cyc(1);
    word_vld = 1'b0;
    por_n = 1'b1;
    after_flow(7);
    chk("word valid", vld, 1'b1);
    cfg_pins = 8'hc3; // Later hard and soft flows must not pick these up
    bsrc = 3'h2;
  endtask
  // Hard flow sources, with a boot word strobe that must be refused
  task automatic hard_flow(input int src);
    int b;
    case (src)
      0: begin wd_zero = 1'b1; b = 4; end
      1: begin link_req = 1'b1; b = 2; end
      2: begin sw_hard = 1'b1; b = 1; end
      default: begin ext_hard = 1'b1; b = 6; end
    endcase
    cyc(1);
    {wd_zero, link_req, sw_hard} = 3'b000;
    word = 32'hdead_beef;
    word_vld = 1'b1;
    cyc(5);
    word_vld = 1'b0;
    ext_hard = 1'b0;
    chk("hard oe", hard_oe, 1'b1);
    chk("soft wire", soft_n_w, 1'b0);
    chk("pll", pll_rst, 1'b0);
    after_flow(b);
  endtask
  task automatic soft_flow(input int src);
    int b;
    b = 3;
    case (src)
      0: begin sw_soft = 1'b1; b = 0; end
      1: tap_host = 1'b1;
      2: tap_ir = TAP_EXTEST;
      3: tap_ir = TAP_CLAMP;
      4: tap_ir = TAP_HIGHZ;
      default: begin ext_soft = 1'b1; b = 5; end
    endcase
    cyc(1);
    {sw_soft, tap_host, tap_ir} = {2'b00, 4'hf};
    cyc(5);
    ext_soft = 1'b0;
    chk("soft oe", soft_oe, 1'b1);
    chk("hard oe", hard_oe, 1'b0);
    chk("core", core_rst, 1'b1);
    after_flow(b);
  endtask
  // Outside soft pull during a hard flow, and a disabled watchdog, start nothing
  task automatic t_ignore();
    wd_en = 1'b0;
    wd_zero = 1'b1;
    cyc(6);
    chk("ready", ready, 1'b1);
    {wd_en, wd_zero} = 2'b10;
    sw_hard = 1'b1;
    cyc(1);
    sw_hard = 1'b0;
    cyc(10);
    ext_soft = 1'b1;
    cyc(10);
    ext_soft = 1'b0;
    after_flow(1);
    cyc(20);
    chk("ready", ready, 1'b1);
  endtask
  // Concurrent requests take the widest flow; power-on preempts a hard flow
  task automatic t_prio();
    {sw_hard, sw_soft} = 2'b11;
    cyc(1);
    {sw_hard, sw_soft} = 2'b00;
    cyc(5);
    chk("hard oe", hard_oe, 1'b1);
    cyc(10);
    por_n = 1'b0;
    cyc(6);
    chk("pll", pll_rst, 1'b1);
    word = 32'h0bad_cafe;
    word_vld = 1'b1;
    cyc(1);
    word_vld = 1'b0;
    por_n = 1'b1;
    cyc(200);
    chk("ready", ready, 1'b1);
    chk("new cfg", cfg_o, {8'hc3, 3'h2});
    chk("new word", word_o, 32'h0bad_cafe);
    chk("new valid", vld, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cyc(12);
    reset_n_in = 1'b1;
    cyc(2);
    t_por();
    for (int s = 0; s < 4; s++) begin
      hard_flow(s);
    end
    for (int s = 0; s < 6; s++) begin
      soft_flow(s);
    end
    t_ignore();
    t_prio();
    final_report();
  end
endmodule
